//--- hdl/scx_pkg.sv
// Package of the serial channel: register offsets, bit positions, reset values and state codes.
// Assumes a byte-addressed plain register port with 32-bit data words.
package scx_pkg;
  // Register offsets, one aligned word each
  localparam logic [7:0]  OFS_CTRL   = 8'h00;   // control_reg
  localparam logic [7:0]  OFS_MODE   = 8'h04;   // mode_control_reg
  localparam logic [7:0]  OFS_STAT   = 8'h08;   // status_reg
  localparam logic [7:0]  OFS_TXD    = 8'h0c;   // tx_holding_reg
  localparam logic [7:0]  OFS_RXD    = 8'h10;   // rx_holding_reg
  localparam logic [7:0]  OFS_BAUD   = 8'h14;   // 16x tick divider
  localparam logic [7:0]  OFS_OWNID  = 8'h18;   // own multiprocessor address
  // control_reg fields
  localparam int CTL_TXEN  = 0;
  localparam int CTL_RXEN  = 1;
  localparam int CTL_TIE   = 2;
  localparam int CTL_RIE   = 3;
  localparam int CTL_TX_DONE_IRQ_EN  = 4;
  localparam int CTL_CKSEL = 5;                 // clock_source_sel: 1 = external clock
  // mode_control_reg fields
  localparam int MOD_SYNC  = 0;
  localparam int MOD_CHR7  = 1;
  localparam int MOD_PAREN = 2;
  localparam int MOD_ODD   = 3;
  localparam int MOD_STOP2 = 4;
  localparam int MOD_MP    = 5;
  localparam int MOD_MPBT  = 6;                 // multiprocessor bit value to send
  // status_reg fields
  localparam int ST_TX_BUFFER_EMPTY_FLAG   = 0;
  localparam int ST_RX_BUFFER_FULL_FLAG   = 1;
  localparam int ST_OVERRUN_FLAG   = 2;
  localparam int ST_FER    = 3;
  localparam int ST_PER    = 4;
  localparam int ST_TX_DONE_FLAG   = 5;
  localparam int ST_MPB    = 6;
  // Reset values
  localparam logic [6:0]  CTRL_RST   = 7'h00;
  localparam logic [6:0]  MODE_RST   = 7'h00;
  localparam logic [15:0] BAUD_RST   = 16'h001f;
  localparam logic [7:0]  OWNID_RST  = 8'h00;
  // Bit timing in 16x ticks, plus bit indices and bit counts
  localparam logic [3:0]  OVS_LAST   = 4'hf;
  localparam logic [3:0]  OVS_MID    = 4'h7;
  localparam logic [3:0]  SYN_RISE   = 4'h8;
  localparam logic [2:0]  BIT_LAST8  = 3'h7;
  localparam logic [2:0]  BIT_LAST7  = 3'h6;
  localparam logic [3:0]  SYN_BITS   = 4'h8;
  // One-hot frame states
  typedef enum logic [4:0] {
    FS_IDLE  = 5'b00001,
    FS_START = 5'b00010,
    FS_DATA  = 5'b00100,
    FS_PAR   = 5'b01000,
    FS_STOP  = 5'b10000
  } scx_fs_t;
endpackage

//--- hdl/scx_tick.sv
// Tick source of the serial channel: 16x bit tick and serial clock edge pulses.
// Assumes sck_i is asynchronous to mclk_i and much slower than it.
`timescale 1ns/10ps
module scx_tick (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        ext_i,
  input  wire logic        sck_i,
  input  wire logic [15:0] div_i,
  output logic             tick_o,
  output logic             rise_o,
  output logic             fall_o
);
  typedef struct packed {
    logic        s1;
    logic        s2;
    logic        s3;
    logic [15:0] cnt;
    logic        tick;
    logic        rise;
    logic        fall;
  } scx_tick_t;

  scx_tick_t st_reg;
  scx_tick_t st_next;

  // Divider for the internal clock, edge finder for the external one
  always_comb begin
    st_next      = st_reg;
    st_next.s1   = sck_i;
    st_next.s2   = st_reg.s1;          // First stage feeds only this flop
    st_next.s3   = st_reg.s2;
    st_next.rise = st_reg.s2 & ~st_reg.s3;
    st_next.fall = ~st_reg.s2 & st_reg.s3;
    st_next.tick = 1'b0;
    if (ext_i) begin
      st_next.cnt  = 16'h0000;
      st_next.tick = st_reg.s2 & ~st_reg.s3;
    end else if (st_reg.cnt >= div_i) begin
      st_next.cnt  = 16'h0000;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 16'h0001;
    end
  end

  // State register
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_reg <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, cnt: 16'h0000,
                  tick: 1'b0, rise: 1'b0, fall: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick_o = st_reg.tick;
  assign rise_o = st_reg.rise;
  assign fall_o = st_reg.fall;
endmodule // scx_tick

//--- hdl/scx_serial_channel.sv
// Serial channel: asynchronous and clocked synchronous transmitter and receiver with registers.
// Assumes a plain register port on mclk_i; rxd_i and sck_i come from outside the clock domain.
// Operation
// - clearing tx enable empties buffer, resets shifter
// - clearing rx enable keeps flags and data
// - cleared empty flag means load holding register
// - after load set empty flag, maybe interrupt
// - frame opens with zero start, LSB first
// - optional parity or multiprocessor bit follows
// - one or two stop bits, then mark
// - at stop, chain next byte or finish
// - receiver aligns on start, shifts LSB first
// - check parity and first stop bit only
// - good frame fills rx holding, sets full
// - any error flag with enable raises error
// - set error flags block further reception, except alongside a synchronous transmit
// - full buffer at completion sets overrun, discards
// - framing or parity error still stores byte
// - address frames carry mark bit one
// - skip frames until matching address frame
// - multiprocessor format disables parity entirely
// - synchronous bits change falling, sampled rising
// - internal synchronous clock: eight pulses, idle high
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/10ps
module scx_serial_channel (
  input  wire logic               mclk_i,
  input  wire logic               rst_i,
  input  wire logic [7:0]         addr_i,
  input  wire logic [31:0]        wdata_i,
  input  wire logic               wr_i,
  input  wire logic               rd_i,
  output logic      [31:0]        rdata_o,
  input  wire logic               rxd_i,
  output logic                    txd_o,
  input  wire logic               sck_i,
  output logic                    sck_o,
  output logic                    sck_oe_n_o,
  output logic                    tx_empty_irq_o,
  output logic                    tx_done_irq_o,
  output logic                    rx_full_irq_o,
  output logic                    rx_error_irq_o
);
  import scx_pkg::*;

  typedef struct packed {
    logic [6:0]  ctrl;
    logic [6:0]  mode;
    logic [15:0] baud;
    logic [7:0]  own_id;
    logic [7:0]  tx_hold;
    logic [7:0]  rx_hold;
    logic        tx_buffer_empty_flag;
    logic        rx_buffer_full_flag;
    logic        overrun_flag;
    logic        framing_flag;
    logic        per;
    logic        tx_done_flag;
    logic        mpb;
    logic        mp_match;
    logic        rx_perr;
    logic        rx_m;
    logic        rx_s;
    scx_fs_t     tx_st;
    logic [3:0]  tx_cnt;
    logic [2:0]  tx_bit;
    logic [7:0]  tx_sh;
    logic        tx_pbit;
    logic        tx_stop2;
    logic        txd;
    scx_fs_t     rx_st;
    logic [3:0]  rx_cnt;
    logic [2:0]  rx_bit;
    logic [7:0]  rx_sh;
    logic        sy_act;
    logic        sy_tx;
    logic [3:0]  sy_cnt;
    logic [3:0]  sy_n;
    logic        sck;
    logic [31:0] rdata;
  } scx_state_t;

  scx_state_t s_reg;
  scx_state_t s_next;
  logic       tick;
  logic       ext_rise;
  logic       ext_fall;

  // 16x tick from the divider or the external clock pin
  scx_tick u_tick (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .ext_i  (s_reg.ctrl[CTL_CKSEL]),
    .sck_i  (sck_i),
    .div_i  (s_reg.baud),
    .tick_o (tick),
    .rise_o (ext_rise),
    .fall_o (ext_fall)
  );

  // Whole channel next state
  always_comb begin
    logic       sync_m;
    logic       ext_ck;
    logic       err_any;
    logic       tx_load;
    logic       rx_done;
    logic [7:0] rx_data;
    logic       rx_fe;
    logic       rx_pe;
    logic       rx_mpbv;
    logic       sy_fall;
    logic       sy_rise;
    logic [2:0] last_bit;
    s_next   = s_reg;
    sync_m   = s_reg.mode[MOD_SYNC];
    ext_ck   = s_reg.ctrl[CTL_CKSEL];
    err_any  = s_reg.overrun_flag | s_reg.framing_flag | s_reg.per;
    tx_load  = 1'b0;
    rx_done  = 1'b0;
    rx_data  = s_reg.rx_sh;
    rx_fe    = 1'b0;
    rx_pe    = 1'b0;
    rx_mpbv  = 1'b0;
    sy_fall  = 1'b0;
    sy_rise  = 1'b0;
    last_bit = s_reg.mode[MOD_CHR7] ? BIT_LAST7 : BIT_LAST8;
    s_next.rx_m = rxd_i;
    s_next.rx_s = s_reg.rx_m;             // First stage feeds only this flop

    // Register writes; hardware sets below win over these clears
    if (wr_i) begin
      case (addr_i)
        OFS_CTRL:  s_next.ctrl    = wdata_i[6:0];
        OFS_MODE:  s_next.mode    = wdata_i[6:0];
        OFS_TXD:   s_next.tx_hold = wdata_i[7:0];
        OFS_BAUD:  s_next.baud    = wdata_i[15:0];
        OFS_OWNID: s_next.own_id  = wdata_i[7:0];
        OFS_STAT: begin
          // Writing 0 to bits 0 to 4 clears a flag (bit 0 also the done flag), writing 1 leaves it
          if (!wdata_i[ST_TX_BUFFER_EMPTY_FLAG]) begin
            s_next.tx_buffer_empty_flag = 1'b0;
            s_next.tx_done_flag = 1'b0;
          end
          if (!wdata_i[ST_RX_BUFFER_FULL_FLAG]) s_next.rx_buffer_full_flag = 1'b0;
          if (!wdata_i[ST_OVERRUN_FLAG]) s_next.overrun_flag = 1'b0;
          if (!wdata_i[ST_FER])  s_next.framing_flag  = 1'b0;
          if (!wdata_i[ST_PER])  s_next.per  = 1'b0;
        end
        default: ;
      endcase
    end

    // Register reads, answered in the next cycle; unmapped reads zero
    s_next.rdata = 32'h0000_0000;
    if (rd_i) begin
      case (addr_i)
        OFS_CTRL:  s_next.rdata = {25'h0, s_reg.ctrl};
        OFS_MODE:  s_next.rdata = {25'h0, s_reg.mode};
        OFS_STAT:  s_next.rdata = {25'h0, s_reg.mpb, s_reg.tx_done_flag, s_reg.per, s_reg.framing_flag,
                                   s_reg.overrun_flag, s_reg.rx_buffer_full_flag, s_reg.tx_buffer_empty_flag};
        OFS_TXD:   s_next.rdata = {24'h0, s_reg.tx_hold};
        OFS_RXD:   s_next.rdata = {24'h0, s_reg.rx_hold};
        OFS_BAUD:  s_next.rdata = {16'h0, s_reg.baud};
        OFS_OWNID: s_next.rdata = {24'h0, s_reg.own_id};
        default:   s_next.rdata = 32'h0000_0000;
      endcase
    end

    if (!sync_m) begin
      // Asynchronous transmitter, 16 ticks per bit
      if (s_reg.tx_st == FS_IDLE) begin
        if (s_reg.ctrl[CTL_TXEN] && !s_reg.tx_buffer_empty_flag) begin
          tx_load = 1'b1;
        end
      end else if (tick) begin
        s_next.tx_cnt = s_reg.tx_cnt + 4'h1;
        if (s_reg.tx_cnt == OVS_LAST) begin
          case (s_reg.tx_st)
            FS_START: begin
              s_next.tx_st  = FS_DATA;
              s_next.tx_bit = 3'h0;
              s_next.txd    = s_reg.tx_sh[0];
            end
            FS_DATA: begin
              s_next.tx_sh  = {1'b0, s_reg.tx_sh[7:1]};
              s_next.tx_bit = s_reg.tx_bit + 3'h1;
              s_next.txd    = s_reg.tx_sh[1];
              if (s_reg.tx_bit == last_bit) begin
                if (s_reg.mode[MOD_MP] || s_reg.mode[MOD_PAREN]) begin
                  s_next.tx_st = FS_PAR;
                  s_next.txd   = s_reg.tx_pbit;
                end else begin
                  s_next.tx_st = FS_STOP;
                  s_next.txd   = 1'b1;
                end
              end
            end
            FS_PAR: begin
              s_next.tx_st = FS_STOP;
              s_next.txd   = 1'b1;
            end
            FS_STOP: begin
              if (s_reg.mode[MOD_STOP2] && !s_reg.tx_stop2) begin
                s_next.tx_stop2 = 1'b1;
              end else if (s_reg.ctrl[CTL_TXEN] && !s_reg.tx_buffer_empty_flag) begin
                tx_load = 1'b1;
              end else begin
                s_next.tx_st = FS_IDLE;
                s_next.tx_done_flag  = 1'b1;
              end
            end
            default: s_next.tx_st = FS_IDLE;
          endcase
        end
      end

      // Asynchronous receiver, centre sampling from the start edge
      if (s_reg.ctrl[CTL_RXEN] && tick) begin
        s_next.rx_cnt = s_reg.rx_cnt + 4'h1;
        case (s_reg.rx_st)
          FS_IDLE: begin
            s_next.rx_cnt = 4'h0;
            if (!s_reg.rx_s && !err_any) begin
              s_next.rx_st = FS_START;
            end
          end
          FS_START: begin
            if (s_reg.rx_cnt == OVS_MID) begin
              s_next.rx_cnt = 4'h0;
              s_next.rx_bit = 3'h0;
              s_next.rx_sh  = 8'h00;
              s_next.rx_st  = s_reg.rx_s ? FS_IDLE : FS_DATA;          // Glitch rejected
            end
          end
          FS_DATA: begin
            if (s_reg.rx_cnt == OVS_LAST) begin
              s_next.rx_bit = s_reg.rx_bit + 3'h1;
              if (s_reg.mode[MOD_CHR7]) begin
                s_next.rx_sh = {1'b0, s_reg.rx_s, s_reg.rx_sh[6:1]};
              end else begin
                s_next.rx_sh = {s_reg.rx_s, s_reg.rx_sh[7:1]};
              end
              if (s_reg.rx_bit == last_bit) begin
                s_next.rx_st = (s_reg.mode[MOD_MP] || s_reg.mode[MOD_PAREN]) ? FS_PAR : FS_STOP;
              end
            end
          end
          FS_PAR: begin
            if (s_reg.rx_cnt == OVS_LAST) begin
              s_next.rx_st = FS_STOP;
              if (s_reg.mode[MOD_MP]) begin
                s_next.mpb = s_reg.rx_s;
              end else begin
                s_next.rx_perr = ^{s_reg.rx_sh, s_reg.rx_s, s_reg.mode[MOD_ODD]};
              end
            end
          end
          FS_STOP: begin
            if (s_reg.rx_cnt == OVS_LAST) begin
              s_next.rx_st = FS_IDLE;
              rx_done      = 1'b1;
              rx_fe        = ~s_reg.rx_s;
              rx_pe        = s_reg.mode[MOD_PAREN] & ~s_reg.mode[MOD_MP] & s_reg.rx_perr;
              rx_mpbv      = s_reg.mode[MOD_MP] & s_reg.mpb;
            end
          end
          default: s_next.rx_st = FS_IDLE;
        endcase
      end
    end else begin
      // Synchronous engine: 8 bits per character on a shared clock
      if (!s_reg.sy_act) begin
        s_next.sck    = 1'b1;
        s_next.sy_cnt = 4'h0;
        s_next.sy_n   = 4'h0;
        if (s_reg.ctrl[CTL_TXEN] && !s_reg.tx_buffer_empty_flag) begin
          tx_load = 1'b1;
        end else if (s_reg.ctrl[CTL_RXEN] && !err_any) begin
          s_next.sy_act = 1'b1;
          s_next.sy_tx  = 1'b0;
        end
      end else begin
        if (ext_ck) begin
          sy_fall = ext_fall;
          sy_rise = ext_rise;
        end else if (tick) begin
          s_next.sy_cnt = s_reg.sy_cnt + 4'h1;
          sy_fall       = (s_reg.sy_cnt == 4'h0);
          sy_rise       = (s_reg.sy_cnt == SYN_RISE);
          if (sy_fall) s_next.sck = 1'b0;
          if (sy_rise) s_next.sck = 1'b1;
        end
        if (sy_fall && s_reg.sy_tx) begin
          s_next.txd   = s_reg.tx_sh[0];
          s_next.tx_sh = {1'b0, s_reg.tx_sh[7:1]};
        end
        if (sy_rise) begin
          s_next.rx_sh  = {s_reg.rx_s, s_reg.rx_sh[7:1]};
          s_next.sy_n   = s_reg.sy_n + 4'h1;
          s_next.sy_cnt = SYN_RISE + 4'h1;
          if (s_reg.sy_n == SYN_BITS - 4'h1) begin
            s_next.sy_cnt = 4'h0;
            s_next.sy_n   = 4'h0;
            s_next.sy_act = 1'b0;
            rx_done       = s_reg.ctrl[CTL_RXEN];
            rx_data       = {s_reg.rx_s, s_reg.rx_sh[7:1]};
            if (s_reg.sy_tx) begin
              if (s_reg.ctrl[CTL_TXEN] && !s_reg.tx_buffer_empty_flag) begin
                tx_load = 1'b1;
              end else begin
                s_next.tx_done_flag = 1'b1;                                    // Line keeps MSB
              end
            end
          end
        end
      end
    end

    // Holding register to shifter transfer
    if (tx_load) begin
      s_next.tx_sh    = s_reg.tx_hold;
      s_next.tx_buffer_empty_flag     = 1'b1;
      s_next.tx_done_flag     = 1'b0;
      s_next.tx_cnt   = 4'h0;
      s_next.tx_stop2 = 1'b0;
      if (s_reg.mode[MOD_MP]) begin
        s_next.tx_pbit = s_reg.mode[MOD_MPBT];
      end else if (s_reg.mode[MOD_CHR7]) begin
        s_next.tx_pbit = ^{s_reg.tx_hold[6:0], s_reg.mode[MOD_ODD]};
      end else begin
        s_next.tx_pbit = ^{s_reg.tx_hold, s_reg.mode[MOD_ODD]};
      end
      if (sync_m) begin
        s_next.sy_act = 1'b1;
        s_next.sy_tx  = 1'b1;
      end else begin
        s_next.tx_st = FS_START;
        s_next.txd   = 1'b0;
      end
    end

    // Disables last, so a same-cycle load or bit step cannot undo them
    if (wr_i && addr_i == OFS_CTRL) begin
      if (!wdata_i[CTL_TXEN]) begin
        s_next.tx_buffer_empty_flag  = 1'b1;
        s_next.tx_st = FS_IDLE;
        s_next.txd   = 1'b1;
        s_next.sy_tx = 1'b0;
      end
      if (!wdata_i[CTL_RXEN]) begin
        s_next.rx_st = FS_IDLE;
      end
      if (!wdata_i[CTL_TXEN] && !wdata_i[CTL_RXEN]) begin
        s_next.sy_act = 1'b0;
      end
    end

    // Delivery of a finished character
    if (rx_done) begin
      if (rx_mpbv) begin
        s_next.mp_match = (rx_data == s_reg.own_id);
      end else if (!s_reg.mode[MOD_MP] || s_reg.mp_match || sync_m) begin
        s_next.framing_flag = s_reg.framing_flag | rx_fe;
        s_next.per = s_reg.per | rx_pe;
        if (s_reg.rx_buffer_full_flag) begin
          s_next.overrun_flag = 1'b1;
        end else begin
          s_next.rx_hold = rx_data;
          s_next.rx_buffer_full_flag    = ~(rx_fe | rx_pe);
        end
      end
    end
  end

  // State register
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_reg          <= '0;
      s_reg.ctrl     <= CTRL_RST;
      s_reg.mode     <= MODE_RST;
      s_reg.baud     <= BAUD_RST;
      s_reg.own_id   <= OWNID_RST;
      s_reg.tx_buffer_empty_flag     <= 1'b1;
      s_reg.tx_done_flag     <= 1'b1;
      s_reg.rx_m     <= 1'b1;
      s_reg.rx_s     <= 1'b1;
      s_reg.tx_st    <= FS_IDLE;
      s_reg.rx_st    <= FS_IDLE;
      s_reg.txd      <= 1'b1;
      s_reg.sck      <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // Pins and request lines
  assign rdata_o        = s_reg.rdata;
  assign txd_o          = s_reg.txd;
  assign sck_o          = s_reg.sck;
  assign sck_oe_n_o     = ~(s_reg.mode[MOD_SYNC] & ~s_reg.ctrl[CTL_CKSEL]);
  assign tx_empty_irq_o = s_reg.ctrl[CTL_TIE] & s_reg.tx_buffer_empty_flag;
  assign tx_done_irq_o  = s_reg.ctrl[CTL_TX_DONE_IRQ_EN] & s_reg.tx_done_flag;
  assign rx_full_irq_o  = s_reg.ctrl[CTL_RIE] & s_reg.rx_buffer_full_flag;
  assign rx_error_irq_o = s_reg.ctrl[CTL_RIE] & (s_reg.overrun_flag | s_reg.framing_flag | s_reg.per);
endmodule // scx_serial_channel

//--- tb/scx_serial_channel_checker.sv
// Checker of the serial channel ports: idle levels, flag holds, load timing.
// Assumes the bind below onto scx_serial_channel and the offsets of scx_pkg.
`timescale 1ns/10ps
module scx_serial_channel_checker (
  input wire logic        mclk_i,
  input wire logic        rst_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        rxd_i,
  input wire logic        txd_o,
  input wire logic        sck_i,
  input wire logic        sck_o,
  input wire logic        sck_oe_n_o,
  input wire logic        tx_empty_irq_o,
  input wire logic        tx_done_irq_o,
  input wire logic        rx_full_irq_o,
  input wire logic        rx_error_irq_o
);
  import scx_pkg::*;
  logic stw_reg;
  // Status write seen a cycle late, so an empty flag fall is tied to software
  always_ff @(posedge mclk_i) stw_reg <= wr_i && addr_i == OFS_STAT;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  property p_mark; $fell(rst_i) |-> txd_o && sck_o && sck_oe_n_o; endproperty
  a_mark: assert property (p_mark) else $error("line not idle after reset");
  property p_sck; sck_oe_n_o |-> sck_o; endproperty
  a_sck: assert property (p_sck) else $error("serial clock low while released");
  property p_start; $fell(txd_o) |-> !txd_o [*8]; endproperty
  a_start: assert property (p_start) else $error("transmit bit too short");
  property p_done; tx_done_irq_o |-> txd_o; endproperty
  a_done: assert property (p_done) else $error("done flag outside mark");
  property p_off;
    wr_i && addr_i == OFS_CTRL && !wdata_i[CTL_TXEN] && wdata_i[CTL_TIE] |=> txd_o && tx_empty_irq_o;
  endproperty
  a_off: assert property (p_off) else $error("transmitter not reset on disable");
  property p_full; rx_full_irq_o && !wr_i |=> rx_full_irq_o; endproperty
  a_full: assert property (p_full) else $error("full flag lost");
  property p_err; rx_error_irq_o && !wr_i |=> rx_error_irq_o; endproperty
  a_err: assert property (p_err) else $error("error flag lost");
  property p_load; stw_reg && $fell(tx_empty_irq_o) |-> ##[1:2] tx_empty_irq_o ##[0:2] !txd_o; endproperty
  a_load: assert property (p_load) else $error("holding register not loaded");
endmodule // scx_serial_channel_checker

bind scx_serial_channel scx_serial_channel_checker u_chk (
  .mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .rxd_i, .txd_o,
  .sck_i, .sck_o, .sck_oe_n_o, .tx_empty_irq_o, .tx_done_irq_o, .rx_full_irq_o,
  .rx_error_irq_o
);

//--- tb/scx_far_port.sv
// Far serial port: drives the receive line and decodes the transmit line.
// Assumes sck_i runs free, sixteen rising edges per bit.
`timescale 1ns/10ps
module scx_far_port (
  input  wire logic sck_i,
  input  wire logic txd_i,
  output logic      rxd_o
);
  // Mark level whenever no frame is sent, like a pulled-up line
  initial rxd_o = 1'b1;
  // One bit per sixteen clock edges, first bit first
  task automatic send(input logic [15:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      rxd_o = bits[i];
      repeat (16) @(posedge sck_i);
    end
    rxd_o = 1'b1;
  endtask
  // Centre sampling counted from the start edge
  task automatic recv(input int n, output logic [15:0] bits);
    bits = '0;
    @(negedge txd_i);
    repeat (8) @(posedge sck_i);
    for (int i = 0; i < n; i++) begin
      bits[i] = txd_i;
      repeat (16) @(posedge sck_i);
    end
  endtask
endmodule // scx_far_port

//--- tb/tb_top.sv
// Bench of the serial channel: register tasks, far port, one task per scenario.
// Assumes scx_pkg offsets and a free-running external serial clock.
`timescale 1ns/10ps
module tb_top;
  import scx_pkg::*;
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        sck_i = 1'b0;
  logic [31:0] rdata_o;
  logic        rxd_i, txd_o, sck_o, sck_oe_n_o;
  logic        tx_empty_irq_o, tx_done_irq_o, rx_full_irq_o, rx_error_irq_o;
  int          err_count = 0;
  int          comparisons = 0;
  // Clocks; the serial clock never stops and is offset from the main one
  always #10 mclk_i = ~mclk_i;
  initial begin
    #3;
    forever #80 sck_i = ~sck_i;
  end
  scx_serial_channel dut (
    .mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .rxd_i, .txd_o,
    .sck_i, .sck_o, .sck_oe_n_o, .tx_empty_irq_o, .tx_done_irq_o, .rx_full_irq_o,
    .rx_error_irq_o
  );
  scx_far_port far (.sck_i, .txd_i(txd_o), .rxd_o(rxd_i));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 chk(what, exp, rdata_o);
  endtask
  // Both enables off before any format change
  task automatic cfg(input logic [31:0] mode, input logic [31:0] ctrl);
    wreg(OFS_CTRL, 32'h0);
    wreg(OFS_MODE, mode);
    wreg(OFS_CTRL, ctrl);
  endtask
  task automatic t_tx(input logic [31:0] mode, input logic [7:0] d, input logic [15:0] exp);
    logic [15:0] got;
    cfg(mode, 32'h35);
    fork
      far.recv(11, got);
      begin
        wreg(OFS_TXD, {24'h0, d});
        wreg(OFS_STAT, 32'h7e);
      end
    join
    chk("txframe", {16'h0, exp}, {16'h0, got});
    repeat (200) @(posedge mclk_i);
    rchk("txstat", OFS_STAT, 32'h21);
    chk("txdone", 32'h1, tx_done_irq_o);
    chk("txempty", 32'h1, tx_empty_irq_o);
  endtask
  task automatic t_rx(input logic [15:0] bits, input logic [31:0] st, input logic [31:0] d);
    far.send(bits, 11);
    repeat (20) @(posedge mclk_i);
    rchk("rxstat", OFS_STAT, st);
    rchk("rxdata", OFS_RXD, d);
  endtask
  task automatic t_rx_err();
    // Odd parity here, even parity on the transmit side
    cfg(32'h0c, 32'h2a);
    t_rx({1'b1, 1'b1, 8'h3c, 1'b0}, 32'h23, 32'h3c);
    chk("fullirq", 32'h1, rx_full_irq_o);
    t_rx({1'b1, 1'b1, 8'h99, 1'b0}, 32'h27, 32'h3c);
    chk("errirq", 32'h1, rx_error_irq_o);
    wreg(OFS_CTRL, 32'h28);
    rchk("keepstat", OFS_STAT, 32'h27);
    rchk("keepdata", OFS_RXD, 32'h3c);
    wreg(OFS_STAT, 32'h79);
    wreg(OFS_CTRL, 32'h2a);
    t_rx({1'b0, 1'b1, 8'h01, 1'b0}, 32'h39, 32'h01);
    t_rx({1'b1, 1'b1, 8'h3c, 1'b0}, 32'h39, 32'h01);
  endtask
  // Parity enable left set to show it is ignored in this format
  task automatic t_mp();
    wreg(OFS_STAT, 32'h67);
    cfg(32'h24, 32'h2a);
    wreg(OFS_OWNID, 32'h5a);
    t_rx({1'b1, 1'b0, 8'h11, 1'b0}, 32'h21, 32'h01);
    t_rx({1'b1, 1'b1, 8'h5a, 1'b0}, 32'h61, 32'h01);
    t_rx({1'b1, 1'b0, 8'h76, 1'b0}, 32'h23, 32'h76);
  endtask
  task automatic t_txoff();
    cfg(32'h0, 32'h21);
    wreg(OFS_TXD, 32'h0);
    wreg(OFS_STAT, 32'h7e);
    repeat (300) @(posedge mclk_i);
    wreg(OFS_CTRL, 32'h24);
    #1 chk("txline", 32'h1, txd_o);
    chk("tx_buffer_empty_flag", 32'h1, tx_empty_irq_o);
  endtask
  // Bits taken at each rising serial clock, as a far receiver would
  task automatic t_sync();
    logic [7:0] got = 8'h0;
    int cnt = 0;
    logic prev = 1'b1;
    wreg(OFS_BAUD, 32'h1);
    cfg(32'h01, 32'h01);
    wreg(OFS_TXD, 32'h4b);
    wreg(OFS_STAT, 32'h7e);
    repeat (700) begin
      @(posedge mclk_i);
      #1;
      if (!prev && sck_o) begin
        got = {txd_o, got[7:1]};
        cnt++;
      end
      prev = sck_o;
    end
    chk("syncbyte", 32'h4b, {24'h0, got});
    chk("pulses", 32'h8, cnt);
    chk("msbhold", 32'h0, txd_o);
    chk("sckidle", 32'h1, sck_o);
    chk("sckoe", 32'h0, sck_oe_n_o);
  endtask
  task automatic final_report();
    if (err_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Run about 14500 cycles; the watchdog allows over twice that
  initial begin
    #700000;
    err_count++;
    final_report();
  end
  initial begin
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'b0;
    rchk("status", OFS_STAT, 32'h21);
    rchk("unmapped", 8'h1c, 32'h0);
    t_tx(32'h04, 8'ha5, {1'b1, 1'b0, 8'ha5, 1'b0});
    t_tx(32'h76, 8'h55, {1'b1, 1'b1, 1'b1, 7'h55, 1'b0});
    t_rx_err();
    t_mp();
    t_txoff();
    t_sync();
    final_report();
  end
endmodule // tb_top
